// ---- rtl/cmp_pkg.sv ----
// Package: register map, field layout and shared types of the comparator control block
// Contract
// - Three identical comparator control channels
// - Latched synchronous and raw asynchronous outputs
// - Raw output tracks inputs without clock
// - Mux register: two-bit positive, negative selects
// - Disabled comparator: outputs low, power removed
// - Mode register selects response time
// - Separate positive and negative hysteresis fields
// - Interrupts on rising and falling transitions
// - Edge flags set on matching transitions
// - Flags sticky until software writes zero
// - Output level readable as status bit
// - Enable bit switches comparator on/off
// - Per-edge interrupt enables gate requests
// - Speed field 00 fastest, 11 slowest
// - Hysteresis codes 00 off to 11 20mV
package cmp_pkg;

    // ==========================================
    // Sizes
    localparam int NUM_CMP  = 3;            // Comparator instances
    localparam int ADDR_W   = 8;            // APB address bits decoded

    // ==========================================
    // Register map: per channel a block of four words
    localparam logic [7:0] CH_STRIDE    = 8'h10;    // Bytes per channel
    localparam logic [3:0] OFF_CTRL     = 4'h0;     // Control register
    localparam logic [3:0] OFF_MODE     = 4'h4;     // Mode register
    localparam logic [3:0] OFF_MUX      = 4'h8;     // Input mux register
    localparam logic [7:0] OFF_IRQ_STAT = 8'h30;    // Sticky irq status, clear on read
    localparam logic [7:0] OFF_IRQ_MASK = 8'h34;    // Irq mask

    // ==========================================
    // Control register fields
    localparam int CTRL_ON    = 7;          // Enable bit
    localparam int CTRL_LEVEL = 6;          // Output level, read only
    localparam int CTRL_RISE  = 5;          // Rising edge flag
    localparam int CTRL_FALL  = 4;          // Falling edge flag
    localparam int CTRL_HYP   = 2;          // Positive hysteresis low bit
    localparam int CTRL_HYN   = 0;          // Negative hysteresis low bit

    // Mode register fields
    localparam int MODE_RIE   = 5;          // Rising irq enable
    localparam int MODE_FIE   = 4;          // Falling irq enable
    localparam int MODE_SPD   = 0;          // Speed select low bit

    // Mux register fields
    localparam int MUX_NEG    = 0;          // Negative input select low bit
    localparam int MUX_POS    = 4;          // Positive input select low bit

    // ==========================================
    // Reset values
    localparam logic [1:0] SPEED_RST = 2'h2;    // Mode 2 after reset

    // Hysteresis codes
    typedef enum logic [1:0] {
        HYST_OFF  = 2'h0,   // Disabled
        HYST_5MV  = 2'h1,   // 5 mV
        HYST_10MV = 2'h2,   // 10 mV
        HYST_20MV = 2'h3    // 20 mV
    } hyst_e;

    // Speed codes
    typedef enum logic [1:0] {
        SPD_FAST  = 2'h0,   // Fastest, highest power
        SPD_MID1  = 2'h1,   // Mode 1
        SPD_MID2  = 2'h2,   // Mode 2
        SPD_SLOW  = 2'h3    // Slowest, lowest power
    } speed_e;

    // Per-channel software settings
    typedef struct packed {
        logic       cmp_on;             // Enable
        hyst_e      cmp_pos_hyst;       // Positive hysteresis
        hyst_e      cmp_neg_hyst;       // Negative hysteresis
        logic       cmp_rise_irq_en;    // Rising irq enable
        logic       cmp_fall_irq_en;    // Falling irq enable
        speed_e     cmp_speed_sel;      // Response mode
        logic [1:0] cmp_pos_input_sel;  // Positive input select
        logic [1:0] cmp_neg_input_sel;  // Negative input select
    } cmp_cfg_s;

    // Analog control to one comparator
    typedef struct packed {
        logic       power;              // Supply on
        hyst_e      pos_hyst;           // Positive hysteresis
        hyst_e      neg_hyst;           // Negative hysteresis
        speed_e     speed;              // Response mode
        logic [1:0] pos_sel;            // Positive input
        logic [1:0] neg_sel;            // Negative input
    } analog_ctl_s;

endpackage

// ---- rtl/analog_comparator_control.sv ----
// Module: APB control and status logic for three analog comparators
`timescale 1ns/1ns
`default_nettype none

module analog_comparator_control #(
    parameter int NCMP = cmp_pkg::NUM_CMP   // Comparator instances
) (
    input  wire logic                     clk,            // System clock
    input  wire logic                     reset_n,        // Sync reset, active low
    input  wire logic                     psel,           // APB select
    input  wire logic                     penable,        // APB enable
    input  wire logic                     pwrite,         // APB direction
    input  wire logic [31:0]              paddr,          // APB address
    input  wire logic [31:0]              pwdata,         // APB write data
    output logic                          pready,         // APB ready
    output logic [31:0]                   prdata,         // APB read data
    output logic                          pslverr,        // APB error
    input  wire logic [NCMP-1:0]          cmp_analog,     // Comparator decisions
    output logic [NCMP-1:0]               cmp_raw_out,    // Raw output to pins
    output logic [NCMP-1:0]               cmp_latched_out,// Latched output to pins
    output cmp_pkg::analog_ctl_s [NCMP-1:0] analog_ctl,   // Analog settings
    output logic                          irq             // Interrupt level
);

    // ==========================================
    // Overview
    // Three identical channels, one decoder
    // Per channel: control, mode, input select
    // Raw output: gate on decision, no clock
    // Keeps tracking with the clock stopped
    // Latched output, level bit and edges
    // all use the synchronised copy
    // No metastable level reaches software
    // Flags: set by hardware
    // Flags: cleared by a written zero
    // A written one leaves a flag alone
    // Read-modify-write loses an edge between read and write
    // Irq status apart from the flags
    // Status needs the edge enable
    // Mask gates status onto the line
    // Status read clears the word
    // Edge in the same cycle still lands
    // One wait cycle per access
    // Ready stands for one cycle
    // Unmapped words: error, no effect
    // Spare channel word: zero, no error
    // Analog controls move with the answer
    // Macro never sees half a setting
    // Edges seen while a channel is off
    // Clear flags after on or mode change
    // Hazard: chain is zero after reset
    // High input then gives one rise

    // ==========================================
    // Register map, base n*0x10 per channel
    //   +0x0 control word
    //        on, level, rise, fall flags
    //        positive, negative hysteresis
    //   +0x4 mode word
    //        rise, fall irq enables, speed
    //   +0x8 input select word
    //   +0xc spare, reads zero
    //   0x30 irq status, clear on read
    //   0x34 irq mask, same layout
    //   Bit 2n rise, 2n+1 fall of channel n
    // Hysteresis: off, 5, 10, 20 mV
    // Speed: fastest to slowest

    // ==========================================
    // Access timing
    //   cycle 0: setup, nothing taken
    //   cycle 1: access seen, answer built
    //   cycle 2: ready, data, error, writes
    //   cycle 3: idle or next setup
    // Edge timing after an input change
    //   edge 1: first stage
    //   edge 2: settled level
    //   edge 3: flag and status set
    //   edge 3: irq line set with status

    // ==========================================
    // Limitations
    //   No glitch filter
    //   Pulse under one clock: raw only
    //   Input select codes pass unchecked
    //   Low address byte only: map repeats
    //   Raw output is the one gate output
    //   It must work with the clock stopped

    // ==========================================
    // State
    cmp_pkg::cmp_cfg_s [NCMP-1:0] cfg, next_cfg;          // Settings
    logic [NCMP-1:0]  sync1, sync2, sync3;                // Synchroniser and history
    logic [NCMP-1:0]  rise_flag, fall_flag;               // Sticky edge flags
    logic [NCMP-1:0]  next_rise_flag, next_fall_flag;     // Next flags
    logic [2*NCMP-1:0] irq_stat, next_irq_stat;           // Irq status
    logic [2*NCMP-1:0] irq_mask, next_irq_mask;           // Irq mask
    logic [31:0]      next_prdata;                        // Read data
    logic             next_pready, next_pslverr;          // Bus answer
    logic [NCMP-1:0]  next_latched;                       // Latched outputs
    cmp_pkg::analog_ctl_s [NCMP-1:0] next_analog;         // Analog controls
    logic             next_irq;                           // Interrupt
    logic [NCMP-1:0]  rise_ev, fall_ev;                   // Edge events

    // Access decode; answer in the second access cycle
    logic       acc;                                      // Access phase
    logic       wr, rd;                                   // Write, read
    logic [7:0] a;                                        // Byte address
    // Ready high blocks a second take of one access
    assign acc = psel & penable & ~pready;
    assign wr  = acc & pwrite;
    assign rd  = acc & ~pwrite;
    assign a   = paddr[cmp_pkg::ADDR_W-1:0];

    // ==========================================
    // Raw path: combinational, works with clock stopped
    always_comb begin
        // Default all low, then gate by enable
        cmp_raw_out = cmp_analog & {NCMP{1'b0}};
        for (int i = 0; i < NCMP; i++) begin
            cmp_raw_out[i] = cmp_analog[i] & cfg[i].cmp_on;
        end
    end

    // ==========================================
    // Edge detection per channel
    // Same logic for every channel
    for (genvar g = 0; g < NCMP; g++) begin : g_edge
        // Rise: settled level high, history low
        assign rise_ev[g] = sync2[g] & ~sync3[g];
        // Fall: settled level low, history high
        assign fall_ev[g] = ~sync2[g] & sync3[g];
    end

    // ==========================================
    // Next state of registers and bus
    always_comb begin
        logic [7:0] ch_base;
        // Defaults: hold state, ready on access, no data, no error
        ch_base        = 8'h00;
        next_cfg       = cfg;
        next_rise_flag = rise_flag;
        next_fall_flag = fall_flag;
        next_irq_stat  = irq_stat;
        next_irq_mask  = irq_mask;
        next_prdata    = 32'h0000_0000;
        next_pready    = acc;
        next_pslverr   = 1'b0;
        // Read of the status register clears it; new events still win
        if (rd && a == cmp_pkg::OFF_IRQ_STAT) begin
            next_irq_stat = '0;
            next_prdata   = 32'(irq_stat);
        end
        // Mask write replaces every bit
        if (wr && a == cmp_pkg::OFF_IRQ_MASK) begin
            next_irq_mask = pwdata[2*NCMP-1:0];
        end
        // Mask read back
        if (rd && a == cmp_pkg::OFF_IRQ_MASK) begin
            next_prdata = 32'(irq_mask);
        end
        // Above the channels only status and mask
        if (acc && a >= 8'(NCMP * cmp_pkg::CH_STRIDE) && a != cmp_pkg::OFF_IRQ_STAT
            && a != cmp_pkg::OFF_IRQ_MASK) begin
            next_pslverr = 1'b1;                               // Unmapped
        end
        for (int i = 0; i < NCMP; i++) begin
            // Base byte address of this channel
            ch_base = 8'(i * cmp_pkg::CH_STRIDE);
            // Control register
            if (a == ch_base + 8'(cmp_pkg::OFF_CTRL)) begin
                // Write: enable, hysteresis, flag clears
                if (wr) begin
                    next_cfg[i].cmp_on       = pwdata[cmp_pkg::CTRL_ON];
                    next_cfg[i].cmp_pos_hyst =
                        cmp_pkg::hyst_e'(pwdata[cmp_pkg::CTRL_HYP +: 2]);
                    next_cfg[i].cmp_neg_hyst =
                        cmp_pkg::hyst_e'(pwdata[cmp_pkg::CTRL_HYN +: 2]);
                    // Writing zero clears; writing one leaves as is
                    if (!pwdata[cmp_pkg::CTRL_RISE]) next_rise_flag[i] = 1'b0;
                    if (!pwdata[cmp_pkg::CTRL_FALL]) next_fall_flag[i] = 1'b0;
                end
                // Read: settings, level, flags
                if (rd) begin
                    next_prdata[cmp_pkg::CTRL_ON]      = cfg[i].cmp_on;
                    next_prdata[cmp_pkg::CTRL_LEVEL]   = cmp_latched_out[i];
                    next_prdata[cmp_pkg::CTRL_RISE]    = rise_flag[i];
                    next_prdata[cmp_pkg::CTRL_FALL]    = fall_flag[i];
                    next_prdata[cmp_pkg::CTRL_HYP +: 2] = cfg[i].cmp_pos_hyst;
                    next_prdata[cmp_pkg::CTRL_HYN +: 2] = cfg[i].cmp_neg_hyst;
                end
            end
            // Mode register
            if (a == ch_base + 8'(cmp_pkg::OFF_MODE)) begin
                // Write: edge irq enables, speed
                if (wr) begin
                    next_cfg[i].cmp_rise_irq_en = pwdata[cmp_pkg::MODE_RIE];
                    next_cfg[i].cmp_fall_irq_en = pwdata[cmp_pkg::MODE_FIE];
                    next_cfg[i].cmp_speed_sel   =
                        cmp_pkg::speed_e'(pwdata[cmp_pkg::MODE_SPD +: 2]);
                end
                // Read: unused bits stay zero
                if (rd) begin
                    next_prdata[cmp_pkg::MODE_RIE]     = cfg[i].cmp_rise_irq_en;
                    next_prdata[cmp_pkg::MODE_FIE]     = cfg[i].cmp_fall_irq_en;
                    next_prdata[cmp_pkg::MODE_SPD +: 2] = cfg[i].cmp_speed_sel;
                end
            end
            // Mux register
            if (a == ch_base + 8'(cmp_pkg::OFF_MUX)) begin
                // Write: upper bits ignored
                if (wr) begin
                    next_cfg[i].cmp_pos_input_sel = pwdata[cmp_pkg::MUX_POS +: 2];
                    next_cfg[i].cmp_neg_input_sel = pwdata[cmp_pkg::MUX_NEG +: 2];
                end
                // Read: both selects
                if (rd) begin
                    next_prdata[cmp_pkg::MUX_POS +: 2] = cfg[i].cmp_pos_input_sel;
                    next_prdata[cmp_pkg::MUX_NEG +: 2] = cfg[i].cmp_neg_input_sel;
                end
            end
            // Edges set flags; set wins over a clear in the same cycle
            if (rise_ev[i]) next_rise_flag[i] = 1'b1;
            if (fall_ev[i]) next_fall_flag[i] = 1'b1;
            // Enabled edges raise sticky interrupt status
            if (rise_ev[i] && cfg[i].cmp_rise_irq_en) next_irq_stat[2*i]   = 1'b1;
            if (fall_ev[i] && cfg[i].cmp_fall_irq_en) next_irq_stat[2*i+1] = 1'b1;
        end
        // Read data holds between answers
        if (!next_pready) begin
            next_prdata  = prdata;
        end
    end

    // ==========================================
    // Latched outputs and analog controls
    always_comb begin
        // Defaults cover every bit
        next_latched = '0;
        next_analog  = '0;
        for (int i = 0; i < NCMP; i++) begin
            next_latched[i]         = sync2[i] & cfg[i].cmp_on;
            next_analog[i].power    = next_cfg[i].cmp_on;
            next_analog[i].pos_hyst = next_cfg[i].cmp_pos_hyst;
            next_analog[i].neg_hyst = next_cfg[i].cmp_neg_hyst;
            next_analog[i].speed    = next_cfg[i].cmp_speed_sel;
            next_analog[i].pos_sel  = next_cfg[i].cmp_pos_input_sel;
            next_analog[i].neg_sel  = next_cfg[i].cmp_neg_input_sel;
        end
        // Shared line: any unmasked status bit
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk) begin
        // Reset: channels off, speed mode 2
        if (!reset_n) begin
            for (int i = 0; i < NCMP; i++) begin
                cfg[i] <= '{cmp_on: 1'b0, cmp_pos_hyst: cmp_pkg::HYST_OFF,
                            cmp_neg_hyst: cmp_pkg::HYST_OFF, cmp_rise_irq_en: 1'b0,
                            cmp_fall_irq_en: 1'b0,
                            cmp_speed_sel: cmp_pkg::speed_e'(cmp_pkg::SPEED_RST),
                            cmp_pos_input_sel: 2'h0, cmp_neg_input_sel: 2'h0};
                analog_ctl[i] <= '{power: 1'b0, pos_hyst: cmp_pkg::HYST_OFF,
                                   neg_hyst: cmp_pkg::HYST_OFF,
                                   speed: cmp_pkg::speed_e'(cmp_pkg::SPEED_RST),
                                   pos_sel: 2'h0, neg_sel: 2'h0};
            end
            // Chain, flags, status and bus answer
            sync1           <= '0;
            sync2           <= '0;
            sync3           <= '0;
            rise_flag       <= '0;
            fall_flag       <= '0;
            irq_stat        <= '0;
            irq_mask        <= '0;
            prdata          <= 32'h0000_0000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            cmp_latched_out <= '0;
            irq             <= 1'b0;
        end else begin
            // Normal run: take the next values
            cfg             <= next_cfg;
            analog_ctl      <= next_analog;
            sync1           <= cmp_analog & {NCMP{1'b1}};
            sync2           <= sync1;
            sync3           <= sync2;
            rise_flag       <= next_rise_flag;
            fall_flag       <= next_fall_flag;
            irq_stat        <= next_irq_stat;
            irq_mask        <= next_irq_mask;
            prdata          <= next_prdata;
            pready          <= next_pready;
            pslverr         <= next_pslverr;
            cmp_latched_out <= next_latched;
            irq             <= next_irq;
        end
    end

endmodule

`default_nettype wire

// ---- verification/cmp_analog_model.sv ----
// Model of the three analog comparator decisions seen by the control block
`timescale 1ns/1ns
`default_nettype none

module cmp_analog_model #(
    parameter int N = 3                     // Comparator instances
) (
    input  wire logic         clk,          // System clock
    input  wire logic [N-1:0] target,       // Commanded input relation
    input  wire logic         slow,         // Slow response selected
    output logic      [N-1:0] cmp_analog    // Comparator decisions
);
    logic [N-1:0] stage1;                   // First response delay stage
    logic [N-1:0] stage2;                   // Second response delay stage

    // ==========================================
    // Slow response lags two cycles, prompt one follows at once
    always_ff @(posedge clk) begin
        stage1 <= target;
        stage2 <= stage1;
    end
    assign cmp_analog = slow ? stage2 : target;
endmodule

`default_nettype wire

// ---- verification/analog_comparator_control_checker.sv ----
// Checker: port-level properties of the comparator control block
`timescale 1ns/1ns
`default_nettype none

module acc_checker #(
    parameter int NCMP = 3                                  // Comparator instances
) (
    input wire logic                            clk,
    input wire logic                            reset_n,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [31:0]                     paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic                            pready,
    input wire logic [31:0]                     prdata,
    input wire logic                            pslverr,
    input wire logic [NCMP-1:0]                 cmp_analog,
    input wire logic [NCMP-1:0]                 cmp_raw_out,
    input wire logic [NCMP-1:0]                 cmp_latched_out,
    input wire cmp_pkg::analog_ctl_s [NCMP-1:0] analog_ctl,
    input wire logic                            irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ==========================================
    // Access phase taken by the slave
    sequence s_taken;
        psel && penable && !pready;
    endsequence

    chk_ready_after: assert property (s_taken |=> pready)
        else $error("no ready after access");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    chk_raw_gated: assert property ((cmp_raw_out & ~cmp_analog) == '0)
        else $error("raw output without decision");
    chk_raw_off: assert property (!analog_ctl[0].power |-> !cmp_raw_out[0])
        else $error("raw output while off");
    chk_latch_off: assert property (!analog_ctl[0].power |=> !cmp_latched_out[0])
        else $error("latched output while off");
    chk_latch_sync: assert property ($rose(cmp_latched_out[0]) |-> $past(cmp_analog[0], 3))
        else $error("latched output skipped synchroniser");
    chk_ctl_write: assert property ($changed(analog_ctl) |-> pready && $past(pwrite))
        else $error("analog control changed without write");
    chk_irq_clear: assert property ($fell(irq) |-> pready)
        else $error("interrupt dropped without access");
endmodule

bind analog_comparator_control acc_checker #(.NCMP(NCMP)) acc_checker_inst (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .cmp_analog, .cmp_raw_out, .cmp_latched_out, .analog_ctl, .irq
);

`default_nettype wire

// ---- verification/tb_top.sv ----
// Testbench: register traffic, edge flags and interrupts of the comparator block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp=%h got=%h", n, e, g); end end

module tb_top;
    localparam int N = 3;                               // Comparator instances
    logic clk = 0, reset_n = 0, psel = 0, penable = 0;  // Clock, reset, APB controls
    logic pwrite = 0, slow = 0, pready, pslverr, irq;   // Direction, model speed, answers
    logic [31:0] paddr = 0, pwdata = 0, prdata;         // APB address and data
    logic [N-1:0] target = 0, cmp_analog, cmp_raw_out, cmp_latched_out;
    cmp_pkg::analog_ctl_s [N-1:0] analog_ctl;           // Analog settings seen
    logic [32:0] eq[$], mq[$];                          // Expected answers and masks
    int mismatches = 0, checked = 0;                    // Counters

    always #10 clk = ~clk;

    analog_comparator_control #(.NCMP(N)) analog_comparator_control_inst (.clk, .reset_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .cmp_analog, .cmp_raw_out, .cmp_latched_out, .analog_ctl, .irq);
    cmp_analog_model #(.N(N)) cmp_analog_model_inst (.clk, .target, .slow, .cmp_analog);

    // ==========================================
    // Monitor: each answer against the oldest note
    always @(posedge clk) begin
        logic [32:0] e, m;
        if (pready === 1'b1 && eq.size() > 0) begin
            e = eq.pop_front();
            m = mq.pop_front();
            `CHK("apb", e & m, {pslverr, prdata} & m)
        end
    end

    // One APB transfer, released after the ready edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [32:0] e, input logic [32:0] m);
        eq.push_back(e);
        mq.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0, 33'h100000000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, {1'b0, e}, 33'h1ffffffff);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] r;
        int c;
        void'($urandom(32'h1924fa25));
        cyc(5);
        reset_n <= 1'b1;
        cyc(1);
        for (c = 0; c < N; c++) begin
            rd(8'(c * 16), 32'h0);
            rd(8'(c * 16 + 4), 32'h2);
            rd(8'(c * 16 + 8), 32'h0);
        end
        // Every hysteresis and speed code, random selects
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            c = k % N;
            wr(8'(c * 16), {28'h0, 2'(k), 2'(3 - k)});
            wr(8'(c * 16 + 4), {r[31:6], r[5:4], r[3:2], 2'(k)});
            wr(8'(c * 16 + 8), r);
            rd(8'(c * 16), {28'h0, 2'(k), 2'(3 - k)});
            rd(8'(c * 16 + 4), {26'h0, r[5:4], 2'h0, 2'(k)});
            rd(8'(c * 16 + 8), r & 32'h33);
            `CHK("speed", 2'(k), analog_ctl[c].speed)
            `CHK("hyst", {2'(k), 2'(3 - k)}, {analog_ctl[c].pos_hyst, analog_ctl[c].neg_hyst})
            `CHK("sel", {r[5:4], r[1:0]}, {analog_ctl[c].pos_sel, analog_ctl[c].neg_sel})
        end
        // Unmapped places and a gap word
        xfer(1'b0, 8'h40, 32'h0, 33'h100000000, 33'h1ffffffff);
        xfer(1'b1, 8'h38, 32'hffffffff, 33'h100000000, 33'h100000000);
        rd(8'h0c, 32'h0);
        // Rising edge with slow response; enable write clears both flags
        wr(8'h00, 32'h80);
        wr(8'h04, 32'h30);
        wr(8'h34, 32'h3);
        slow <= 1'b1;
        target <= 3'b001;
        cyc(12);
        `CHK("raw", 3'b001, cmp_raw_out)
        `CHK("latched", 3'b001, cmp_latched_out)
        `CHK("irq", 1'b1, irq)
        rd(8'h00, 32'he0);
        rd(8'h30, 32'h1);
        `CHK("irq", 1'b0, irq)
        // Prompt fall: raw follows with no clock edge
        slow <= 1'b0;
        target <= 3'b000;
        #1;
        `CHK("raw", 3'b000, cmp_raw_out)
        cyc(10);
        rd(8'h00, 32'hb0);
        wr(8'h00, 32'h80);
        rd(8'h00, 32'h80);
        rd(8'h30, 32'h2);
        // Masked edge, then edge enables off
        wr(8'h34, 32'h0);
        target <= 3'b001;
        cyc(10);
        `CHK("irq", 1'b0, irq)
        rd(8'h30, 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h34, 32'h3);
        target <= 3'b000;
        cyc(10);
        rd(8'h30, 32'h0);
        // Disable, then drive the decision high
        wr(8'h00, 32'h0);
        target <= 3'b001;
        cyc(8);
        `CHK("off", 3'b000, {cmp_raw_out[0], cmp_latched_out[0], analog_ctl[0].power})
        // Second reset in mid-run
        reset_n <= 1'b0;
        cyc(5);
        reset_n <= 1'b1;
        cyc(1);
        rd(8'h04, 32'h2);
        close_out();
    end
endmodule

`default_nettype wire
